// *** core/octal_serializer.sv ***
// Eight-channel 10:1 serializer with embedded clock bits and link test.
// Assumes word_strobe marks the rising edge of the shared transmit clock,
// and each lane shifts one bit per clk, twelve per word.
// Inputs are taken as synchronous to clk; every output is a flop.
// The word queue holds one word at the normal strobe rate.
// Functional notes
// - Drive enable low tri-states all eight serial outputs.
// - Drive enable high again resumes prior state; internal state never stops.
// - Any channel can send an internal pseudo-random pattern instead of data.
// - Test uses activate plus four select bits; activate low means no test.
// - Activate high, select 0..7 tests that single channel.
// - Activate high, select 8 tests all channels together.
// - Select 9..F never starts a test.
// - Select inputs default high when undriven, giving no test.
// - All channels share one transmit clock and one bit timer.
// - Parallel words for all channels captured on transmit clock edge.
// - Ten data bits per clock, serialized with embedded clock bits.
// - Lane rate up to twelve times maximum transmit clock.
// - Frame is start bit one, ten data bits, stop bit zero.
// - Twelve bits shifted out per transmit clock period.
// - Sync request high four clocks sends six ones then six zeros.
// - Lane drives only with enable and both power-downs high, sync or not.
`timescale 1ns/1ps
module octal_serializer
    import octal_ser_pkg::*;
#(
    parameter int CH    = octal_ser_pkg::NUM_CH,
    parameter int DEPTH = octal_ser_pkg::FIFO_DEPTH
) (
    input  wire logic                       clk,         // System clock
    input  wire logic                       rstn,        // Sync reset, low
    input  wire logic                       word_strobe, // Transmit clk edge
    input  wire octal_ser_pkg::ch_in_t [CH-1:0] ch_in,   // Per-channel inputs
    input  wire logic                       master_power_down, // Low = off
    input  wire logic                       output_drive_enable, // High drives
    input  wire octal_ser_pkg::test_ctl_t   test_ctl,    // Test controls
    output      logic                       in_ready,    // FIFO has room
    output      logic [CH-1:0]              ser_out,     // Serial lane data
    output      logic [CH-1:0]              ser_oe,      // Lane drive enable
    output      logic [CH-1:0]              test_on      // Lane selected for test
);
    import octal_ser_pkg::*;

    // ==========================================================
    // Functions
    // ==========================================================
    function automatic logic [CH-1:0] test_map(input logic act,
                                               input logic [3:0] sel);
        logic [CH-1:0] m;
        m = '0;
        if (act)
        begin
            if (sel == SEL_ALL)
                m = '1;
            else if (!sel[3])
                m[sel[2:0]] = 1'b1;
        end
        return m;
    endfunction

    function automatic logic [FRAME_BITS-1:0] frame(input word_t w);
        return {START_BIT, w, STOP_BIT};
    endfunction

    // One generator step: shift left, feed back taps 15 and 14
    function automatic logic [14:0] prbs_step(input logic [14:0] s);
        return {s[13:0], s[14] ^ s[13]};
    endfunction

    // Power-down wins over test, test over sync, sync over data, so a
    // powered-down lane never drives whatever the test selects
    function automatic ch_mode_t next_mode(input logic on,
                                           input logic test,
                                           input logic sync);
        ch_mode_t m;
        if (!on)
            m = CH_OFF;
        else if (test)
            m = CH_TEST;
        else if (sync)
            m = CH_SYNC;
        else
            m = CH_DATA;
        return m;
    endfunction

    // ==========================================================
    // Bit timer: twelve lane bits per word period
    // ==========================================================
    logic [3:0] bit_idx_q;
    logic       frame_end;

    // Timer parks on the last bit, so the lane holds the stop level until
    // the next strobe; the lane rate is twelve times the word rate
    assign frame_end = (bit_idx_q == 4'(FRAME_BITS - 1));

    always_ff @(posedge clk)
    begin
        if (!rstn)
            bit_idx_q <= BIT_IDX_RST;
        else if (word_strobe)
            bit_idx_q <= BIT_IDX_RST;
        else if (!frame_end)
            bit_idx_q <= 4'(bit_idx_q + 1'b1);
    end

    // ==========================================================
    // Word capture through the FIFO
    // ==========================================================
    logic [CH*DATA_W-1:0] cap_data;
    logic [CH*DATA_W-1:0] head;
    logic                 head_valid;
    logic                 pop;
    logic                 fifo_ready;

    always_comb
    begin
        for (int i = 0; i < CH; i++)
            cap_data[i*DATA_W +: DATA_W] = ch_in[i].data;
    end

    // Pop one word per frame; source is stalled when the FIFO is full
    assign pop = word_strobe && head_valid;

    word_fifo #(
        .WIDTH (CH*DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_data   (cap_data),
        .in_valid  (word_strobe),
        .in_ready  (fifo_ready),
        .out_data  (head),
        .out_valid (head_valid),
        .out_ready (pop)
    );

    always_ff @(posedge clk)
    begin
        if (!rstn)
            in_ready <= 1'b0;
        else
            in_ready <= fifo_ready;
    end

    // ==========================================================
    // Test control sampling and pattern generator
    // ==========================================================
    test_ctl_t     ctl_q;
    logic [CH-1:0] test_q;
    logic [14:0]   prbs_q;
    word_t         prbs_word;
    logic [14:0]   prbs_nxt;
    logic [CH-1:0] test_nxt;

    always_ff @(posedge clk)
    begin
        // Reset value stands for the pulled-up select pins
        if (!rstn)
            ctl_q <= '{test_active: 1'b0, test_sel: SEL_DEFAULT};
        else
            ctl_q <= test_ctl;
    end

    // Ten steps of the generator per word, so each frame gets fresh bits;
    // the first bit generated goes out first, keeping the line stream one
    // unbroken sequence that the far end can check across frames
    always_comb
    begin
        logic [14:0] s;
        s = prbs_q;
        for (int b = 0; b < DATA_W; b++)
        begin
            prbs_word[DATA_W-1-b] = s[14];
            s = prbs_step(s);
        end
        prbs_nxt = s;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            prbs_q <= PRBS_SEED;
        else if (word_strobe)
            prbs_q <= prbs_nxt;
    end

    // One decode shared by the status, mode and shifter flops
    assign test_nxt = test_map(ctl_q.test_active, ctl_q.test_sel);

    always_ff @(posedge clk)
    begin
        if (!rstn)
            test_q <= '0;
        else if (word_strobe)
            test_q <= test_nxt;
    end

    // ==========================================================
    // Per-channel sync detection, mode and shifter
    // ==========================================================
    logic [1:0]            sync_cnt_q [CH];
    ch_mode_t              mode_q     [CH];
    logic [FRAME_BITS-1:0] shift_q    [CH];

    for (genvar c = 0; c < CH; c++)
    begin : g_ch
        logic     sync_on;
        ch_mode_t mode_nxt;

        assign sync_on = (sync_cnt_q[c] == 2'(SYNC_HOLD - 1));
        assign mode_nxt = next_mode(master_power_down && ch_in[c].pwr_on,
                                    test_nxt[c],
                                    sync_on && ch_in[c].sync_req);

        always_ff @(posedge clk)
        begin
            if (!rstn)
                sync_cnt_q[c] <= SYNC_CNT_RST;
            else if (word_strobe)
            begin
                if (!ch_in[c].sync_req)
                    sync_cnt_q[c] <= SYNC_CNT_RST;
                else if (!sync_on)
                    sync_cnt_q[c] <= 2'(sync_cnt_q[c] + 1'b1);
            end
        end

        // Mode changes only when a new frame is loaded
        always_ff @(posedge clk)
        begin
            if (!rstn)
                mode_q[c] <= CH_OFF;
            else if (word_strobe)
                mode_q[c] <= mode_nxt;
        end

        always_ff @(posedge clk)
        begin
            if (!rstn)
                shift_q[c] <= '0;
            else if (word_strobe)
            begin
                case (mode_nxt)
                    CH_TEST:
                        shift_q[c] <= frame(prbs_word);
                    CH_SYNC:
                        shift_q[c] <= {{SYNC_ONES{1'b1}},
                                       {(FRAME_BITS-SYNC_ONES){1'b0}}};
                    default:
                    begin
                        // An empty queue sends a zero word, still framed
                        if (head_valid)
                            shift_q[c] <= frame(head[c*DATA_W +: DATA_W]);
                        else
                            shift_q[c] <= frame('0);
                    end
                endcase
            end
            else if (!frame_end)
                shift_q[c] <= {shift_q[c][FRAME_BITS-2:0], 1'b0};
        end

        // ==========================================================
        // Lane output stage
        // ==========================================================
        always_ff @(posedge clk)
        begin
            if (!rstn)
                ser_out[c] <= 1'b0;
            else
                ser_out[c] <= shift_q[c][FRAME_BITS-1];
        end

        // Drive enable only gates the pin, so state is kept while disabled;
        // the timer and shifter run on, and the lane resumes mid-stream
        always_ff @(posedge clk)
        begin
            if (!rstn)
                ser_oe[c] <= 1'b0;
            else
                ser_oe[c] <= output_drive_enable
                             && (mode_q[c] != CH_OFF)
                             && master_power_down;
        end
    end

    // ==========================================================
    // Status
    // ==========================================================

    always_ff @(posedge clk)
    begin
        if (!rstn)
            test_on <= '0;
        else
            test_on <= test_q;
    end
endmodule

// *** core/octal_ser_pkg.sv ***
// Package for the eight-channel 10:1 serializer with at-rate link test.
// Assumes one system clock at 125 MHz; word strobe marks each frame start.
package octal_ser_pkg;

    localparam int NUM_CH       = 8;
    localparam int DATA_W       = 10;
    localparam int FRAME_BITS   = 12;
    localparam int SYNC_ONES    = 6;
    localparam int SYNC_HOLD    = 4;
    localparam int FIFO_DEPTH   = 16;

    // Framing bits carried around every word
    localparam logic START_BIT  = 1'b1;
    localparam logic STOP_BIT   = 1'b0;

    // Test select encodings
    localparam logic [3:0] SEL_ALL     = 4'h8;
    localparam logic [3:0] SEL_DEFAULT = 4'hF;

    // Pattern generator: x^15 + x^14 + 1, non-zero seed
    localparam logic [14:0] PRBS_SEED  = 15'h7FFF;

    // Clock rate and bit period of the serial lane
    localparam int CLK_MHZ      = 125;
    localparam int BIT_NS       = 8;
    localparam int BIT_CYCLES   = (BIT_NS * CLK_MHZ + 999) / 1000;

    localparam logic [3:0] BIT_IDX_RST = 4'h0;
    localparam logic [1:0] SYNC_CNT_RST = 2'h0;

    typedef logic [DATA_W-1:0] word_t;

    typedef struct packed {
        logic                  sync_req;
        logic                  pwr_on;
        word_t                 data;
    } ch_in_t;

    typedef struct packed {
        logic test_active;
        logic [3:0] test_sel;
    } test_ctl_t;

    typedef enum logic [1:0] {
        CH_OFF   = 2'b00,
        CH_DATA  = 2'b01,
        CH_SYNC  = 2'b10,
        CH_TEST  = 2'b11
    } ch_mode_t;

endpackage

// *** core/word_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 80,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,       // System clock
    input  wire logic             rstn,      // Sync reset, active low
    input  wire logic [WIDTH-1:0] in_data,   // Write data
    input  wire logic             in_valid,  // Write request
    output      logic             in_ready,  // Not full
    output      logic [WIDTH-1:0] out_data,  // Head word
    output      logic             out_valid, // Not empty
    input  wire logic             out_ready  // Pop
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= AW'(wr_q + 1'b1);
            if (pop)
                rd_q <= AW'(rd_q + 1'b1);
            cnt_q <= (AW+1)'(cnt_q + push - pop);
        end
    end
endmodule

// *** test/lane_receiver.sv ***
// Far-end deserializer model for one serial lane.
// Assumes start bit is sampled on the second clock edge after a strobe.
`timescale 1ns/1ps
module lane_receiver
(
    input  wire logic        clk,     // System clock
    input  wire logic        rstn,    // Sync reset, low
    input  wire logic        strobe,  // Frame launch
    input  wire logic        bit_in,  // Lane level, high when released
    output      logic [11:0] frame_q, // Last whole frame
    output      int          err_q    // Pattern errors seen
);
    logic [3:0]  cnt_q;
    logic [3:0]  fill_q;
    logic [11:0] sr_q;
    logic [14:0] hist_q;

    // ========
    // Frame capture
    always_ff @(posedge clk)
    begin
        if (!rstn)
            cnt_q <= '0;
        else if (strobe)
            cnt_q <= 4'h1;
        else if (cnt_q != 4'h0)
            cnt_q <= (cnt_q == 4'hD) ? 4'h0 : cnt_q + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (cnt_q > 4'h1)
            sr_q <= {sr_q[10:0], bit_in};
        if (cnt_q == 4'hD)
            frame_q <= {sr_q[10:0], bit_in};
    end

    // ========
    // Pattern check; either tap order is accepted since only the
    // recurrence is known, not how the generator is wired
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            hist_q <= '0;
            fill_q <= '0;
            err_q  <= 0;
        end
        else if (cnt_q > 4'h2 && cnt_q < 4'hD)
        begin
            hist_q <= {hist_q[13:0], bit_in};
            if (fill_q != 4'hF)
                fill_q <= fill_q + 4'h1;
            else if (bit_in != (hist_q[13] ^ hist_q[14])
                     && bit_in != (hist_q[0] ^ hist_q[14]))
                err_q <= err_q + 1;
        end
    end
endmodule

// *** test/octal_ser_assertions.sv ***
// Port checker for the octal serializer.
// Assumes word strobes arrive at least twelve clocks apart.
`timescale 1ns/1ps
module octal_ser_assertions
    import octal_ser_pkg::*;
#(
    parameter int CH = 8
) (
    input wire logic                            clk,         // Clock
    input wire logic                            rstn,        // Reset
    input wire logic                            word_strobe, // Strobe
    input wire octal_ser_pkg::ch_in_t [CH-1:0]  ch_in,       // Lanes in
    input wire logic                      master_power_down, // Master on
    input wire logic                    output_drive_enable, // Drive en
    input wire octal_ser_pkg::test_ctl_t        test_ctl,    // Test ctl
    input wire logic                            in_ready,    // Room
    input wire logic [CH-1:0]                   ser_out,     // Lanes
    input wire logic [CH-1:0]                   ser_oe,      // Drive
    input wire logic [CH-1:0]                   test_on      // Test lanes
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // ========
    // Properties
    property p_tristate;
        !output_drive_enable |=> ser_oe == '0;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("lane drives while disabled");
    property p_lane_off;
        word_strobe && !ch_in[0].pwr_on ##1 !ch_in[0].pwr_on |=> !ser_oe[0];
    endproperty
    a_lane_off: assert property (p_lane_off)
        else $error("powered-down lane drives");
    property p_master_off;
        word_strobe && !master_power_down ##1 !master_power_down
            |=> ser_oe == '0;
    endproperty
    a_master_off: assert property (p_master_off)
        else $error("lanes drive in master power-down");
    property p_test_edge;
        $changed(test_on) |-> $past(word_strobe) || $past(word_strobe, 2);
    endproperty
    a_test_edge: assert property (p_test_edge)
        else $error("test lanes changed off a frame edge");
    property p_test_shape;
        $onehot0(test_on) || test_on == '1;
    endproperty
    a_test_shape: assert property (p_test_shape)
        else $error("test lane set not one or all");
    property p_start;
        word_strobe |-> ##2 (ser_out & ser_oe) == ser_oe;
    endproperty
    a_start: assert property (p_start)
        else $error("start bit missing");
    property p_stop;
        word_strobe |-> ##13 (ser_out & ser_oe) == '0;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop bit missing");
    property p_ready;
        rstn [*3] |-> in_ready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("input refused at one word per frame");
    property p_resume;
        $rose(output_drive_enable) && master_power_down && ch_in[0].pwr_on
            |=> ser_oe[0];
    endproperty
    a_resume: assert property (p_resume)
        else $error("lane did not resume driving");

    c_all: cover property (word_strobe && test_ctl.test_sel == SEL_ALL);
    c_sync: cover property (word_strobe && ch_in[3].sync_req);
    c_back: cover property (!output_drive_enable ##1 output_drive_enable);
endmodule

bind octal_serializer octal_ser_assertions #(.CH(CH)) chk
    (.clk(clk), .rstn(rstn), .word_strobe(word_strobe), .ch_in(ch_in),
     .master_power_down(master_power_down), .test_ctl(test_ctl),
     .output_drive_enable(output_drive_enable), .in_ready(in_ready),
     .ser_out(ser_out), .ser_oe(ser_oe), .test_on(test_on));

// *** test/tb_octal_serializer.sv ***
// Self-checking bench for the octal serializer with eight far-end lanes.
// Assumes one frame of latency from strobe to line, as handed over.
`timescale 1ns/1ps
module tb_octal_serializer;
    import octal_ser_pkg::*;
    logic clk, rstn, word_strobe, master_power_down, output_drive_enable;
    ch_in_t [7:0] ch_in;
    test_ctl_t    test_ctl;
    logic       in_ready, en, mp, act;
    logic [7:0] ser_out, ser_oe, test_on, pwr, syn;
    logic [3:0] sel;
    logic [11:0] rx_frame [8];
    int   rx_err [8], base [8];
    int   bad_count, tests_run, cycles, seed;
    word_t prev [8], nxt [8];

    octal_serializer #(.CH(8), .DEPTH(16)) uut
        (.clk(clk), .rstn(rstn), .word_strobe(word_strobe), .ch_in(ch_in),
         .master_power_down(master_power_down), .test_ctl(test_ctl),
         .output_drive_enable(output_drive_enable), .in_ready(in_ready),
         .ser_out(ser_out), .ser_oe(ser_oe), .test_on(test_on));

    // Released lanes idle high, as a failsafe receiver would see them
    for (genvar c = 0; c < 8; c++)
    begin : g_rx
        lane_receiver rx (.clk(clk), .rstn(rstn), .strobe(word_strobe),
            .bit_in(ser_oe[c] ? ser_out[c] : 1'b1),
            .frame_q(rx_frame[c]), .err_q(rx_err[c]));
    end

    // ========
    // Checking
    task automatic cmp(input string n, input logic [11:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h got %h", n, e, g);
        end
    endtask

    task automatic check;
        logic [7:0] t;
        logic       oe;
        t = !act ? 8'h00 : sel < 4'h8 ? 8'h01 << sel
          : sel == SEL_ALL ? 8'hFF : 8'h00;
        cmp("test_on", 12'(t), 12'(test_on));
        cmp("in_ready", 12'h001, 12'(in_ready));
        for (int c = 0; c < 8; c++)
        begin
            oe = en & mp & pwr[c];
            cmp("ser_oe", 12'(oe), 12'(ser_oe[c]));
            if (oe && t[c])
            begin
                cmp("framing", 12'h002, {rx_frame[c][11], rx_frame[c][0]});
                cmp("prbs", 12'h000, 12'(rx_err[c] - base[c]));
            end
            else if (oe && syn[c])
                cmp("sync", 12'hFC0, rx_frame[c]);
            else if (oe)
                cmp("frame", {START_BIT, prev[c], STOP_BIT}, rx_frame[c]);
        end
    endtask

    task automatic frame(input bit chk);
        @(posedge clk);
        base = rx_err;
        for (int c = 0; c < 8; c++)
        begin
            prev[c] = nxt[c];
            nxt[c] = word_t'($random(seed));
            ch_in[c] <= {syn[c], pwr[c], nxt[c]};
        end
        word_strobe <= 1'b1;
        master_power_down <= mp;
        output_drive_enable <= en;
        test_ctl <= {act, sel};
        @(posedge clk);
        word_strobe <= 1'b0;
        repeat (13) @(posedge clk);
        #1;
        if (chk)
            check();
    endtask

    task automatic run(input int w, n);
        repeat (w) frame(0);
        repeat (n) frame(1);
    endtask

    task give_verdict;
        $display("Checks %0d, errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ========
    // Clock, watchdog and sequence
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    initial
    begin
        seed = 43369;
        {rstn, word_strobe, ch_in, act} = '0;
        {master_power_down, output_drive_enable, en, mp} = 4'hF;
        sel = SEL_DEFAULT;
        test_ctl = {1'b0, SEL_DEFAULT};
        {pwr, syn} = 16'hFF00;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmp("oe_reset", 12'h000, {4'h0, ser_oe});
        repeat (3) @(posedge clk);
        run(2, 4);
        // Lane 0 kept off so its power-down check is reached
        pwr = 8'($random(seed)) & 8'hFE;
        run(2, 2);
        pwr = 8'hFF;
        run(1, 0);
        en = 1'b0;
        run(1, 1);
        en = 1'b1;
        run(0, 2);
        mp = 1'b0;
        run(2, 1);
        mp = 1'b1;
        run(2, 1);
        syn = 8'h08;
        run(6, 2);
        syn = 8'h00;
        for (int k = 0; k < 17; k++)
        begin
            act = (k != 16);
            sel = (k == 16) ? SEL_ALL : 4'(k);
            run(3, 2);
        end
        give_verdict();
    end
endmodule
